// File: sit_pkg.sv
// Shared constants and types for the sensor two-wire target port
package sit_pkg;
  localparam logic [6:0] SIT_ADDR_LOW    = 7'h18;
  localparam logic [6:0] SIT_ADDR_HIGH   = 7'h19;
  localparam logic [7:0] SIT_INDEX_RESET = 8'h00;
  localparam logic [3:0] SIT_ACK_BIT     = 4'h8;
  localparam logic [3:0] SIT_LAST_BIT    = 4'h7;
  localparam int         SIT_CLOCK_HZ    = 10000000;
  localparam int         SIT_WDT_US      = 1000;
  localparam int         SIT_WDT_CYCLES  = SIT_WDT_US * (SIT_CLOCK_HZ / 1000000);
  localparam int         SIT_FIFO_DEPTH  = 8;

  // Write beat handed to the register side
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } sit_wbeat_t;

  typedef enum logic [6:0] {
    SIT_IDLE  = 7'b0000001,
    SIT_ADDR  = 7'b0000010,
    SIT_AACK  = 7'b0000100,
    SIT_WRX   = 7'b0001000,
    SIT_WACK  = 7'b0010000,
    SIT_RTX   = 7'b0100000,
    SIT_RACK  = 7'b1000000
  } sit_state_t;
endpackage

// File: sit_fifo.sv
// Small synchronous FIFO for register write beats
`timescale 1ns/1ps
module sit_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic [AW:0]      wptr_next;
  logic [AW:0]      rptr_next;
  logic             push;
  logic             pop;

  always_comb begin
    o_out_valid = wptr_reg != rptr_reg;
    o_in_ready  = (wptr_reg[AW] == rptr_reg[AW]) || (wptr_reg[AW-1:0] != rptr_reg[AW-1:0]);
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wptr_next   = wptr_reg + (AW+1)'(push);
    rptr_next   = rptr_reg + (AW+1)'(pop);
    o_out_data  = mem[rptr_reg[AW-1:0]];
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
    end
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// File: sit_target.sv
// Two-wire bus target port: address match, write/read sequencing, watchdog
//
// Overview of operation
// - Answer address 0x18 with select pin low, 0x19 with it high.
// - Only seven-bit target addresses are decoded.
// - Bus clocks up to 1 MHz are followed by oversampling.
// - Data falling while clock high is start; bus then busy.
// - Data rising while clock high is stop; transfer ends.
// - Ninth clock is acknowledge; receiver pulls data low through it.
// - Stop directly after start without clock toggle is ignored.
// - Matching write address is acknowledged, then data line released.
// - First byte is register index, following bytes are data.
// - Ordinary registers: index advances after each data byte.
// - Special registers: index held fixed on writes (address trap); reads still advance it.
// - Read: index write, repeated start, address with read bit.
// - Read starts at last written index, 0x00 after reset.
// - Controller not-acknowledge ends read; device releases data line.
// - Watchdog releases the bus and returns the port to idle on lock-up.
`timescale 1ns/1ps
module sit_target
  import sit_pkg::*;
#(
  parameter int WDT_CYCLES = SIT_WDT_CYCLES
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  input  wire logic                 i_address_select_pin,
  input  wire logic                 i_bus_clock_pin,
  input  wire logic                 i_bus_data_pin_in,
  output logic                      o_bus_data_pin_out,
  output logic                      o_bus_data_pin_oe,
  input  wire logic                 i_trap_enable,
  input  wire logic [7:0]           i_read_data,
  output logic      [7:0]           o_read_index,
  output logic                      o_write_valid,
  input  wire logic                 i_write_ready,
  output sit_pkg::sit_wbeat_t       o_write_beat,
  output logic                      o_busy,
  output logic                      o_wdt_fired
);
  import sit_pkg::*;
  initial begin
    if (WDT_CYCLES < 16) $error("WDT_CYCLES too small");
  end

  // Two-stage synchronisers; stage one feeds only stage two
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic [1:0] sel_sync_reg;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      sel_sync_reg <= 2'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_bus_clock_pin};
      sda_sync_reg <= {sda_sync_reg[0], i_bus_data_pin_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
      sel_sync_reg <= {sel_sync_reg[0], i_address_select_pin};
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_raw;
  assign scl       = scl_sync_reg[1];
  assign sda       = sda_sync_reg[1];
  assign scl_rise  = scl && !scl_d_reg;
  assign scl_fall  = !scl && scl_d_reg;
  assign start_det = scl && scl_d_reg && sda_d_reg && !sda;
  assign stop_raw  = scl && scl_d_reg && !sda_d_reg && sda;

  function automatic logic addr_hit(input logic [6:0] a, input logic sel);
    addr_hit = a == (sel ? SIT_ADDR_HIGH : SIT_ADDR_LOW);
  endfunction

  sit_state_t  st_reg;
  sit_state_t  st_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic [7:0]  idx_reg;
  logic [7:0]  idx_next;
  logic [7:0]  base_reg;
  logic [7:0]  base_next;
  logic        have_idx_reg;
  logic        have_idx_next;
  logic        rd_reg;
  logic        rd_next;
  logic        drive_reg;
  logic        drive_next;
  logic        toggled_reg;
  logic        toggled_next;
  logic        busy_reg;
  logic        busy_next;
  logic        push_reg;
  logic        push_next;
  sit_wbeat_t  beat_reg;
  sit_wbeat_t  beat_next;
  logic [$clog2(WDT_CYCLES+1)-1:0] wdt_reg;
  logic [$clog2(WDT_CYCLES+1)-1:0] wdt_next;
  logic        wdt_fire;
  logic        fifo_ready;

  // Watchdog counts only while this port holds the data line low
  assign wdt_fire = drive_reg && (wdt_reg == ($bits(wdt_reg))'(WDT_CYCLES));

  always_comb begin
    st_next       = st_reg;
    bit_next      = bit_reg;
    sh_next       = sh_reg;
    idx_next      = idx_reg;
    base_next     = base_reg;
    have_idx_next = have_idx_reg;
    rd_next       = rd_reg;
    drive_next    = drive_reg;
    toggled_next  = toggled_reg || scl_fall;
    busy_next     = busy_reg;
    push_next     = push_reg && !fifo_ready;
    beat_next     = beat_reg;
    wdt_next      = drive_reg ? wdt_reg + ($bits(wdt_reg))'(1) : '0;
    if (wdt_fire) begin
      st_next    = SIT_IDLE;
      drive_next = 1'b0;
      busy_next  = 1'b0;
      wdt_next   = '0;
    end else if (start_det) begin
      st_next      = SIT_ADDR;
      bit_next     = '0;
      drive_next   = 1'b0;
      busy_next    = 1'b1;
      toggled_next = 1'b0;
    end else if (stop_raw && toggled_reg) begin
      st_next    = SIT_IDLE;
      drive_next = 1'b0;
      busy_next  = 1'b0;
    end else begin
      case (st_reg)
        SIT_IDLE: begin
          drive_next = 1'b0;
        end
        SIT_ADDR, SIT_WRX: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda};
            bit_next = bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == SIT_ACK_BIT) begin
            bit_next = '0;
            if (st_reg == SIT_ADDR) begin
              if (addr_hit(sh_reg[7:1], sel_sync_reg[1])) begin
                st_next    = SIT_AACK;
                idx_next   = base_reg;  // Reads restart at the last written index
                drive_next = 1'b1;
                rd_next    = sh_reg[0];
                have_idx_next = 1'b0;
              end else begin
                st_next = SIT_IDLE;
              end
            end else if (!have_idx_reg) begin
              idx_next      = sh_reg;
              base_next     = sh_reg;
              have_idx_next = 1'b1;
              st_next       = SIT_WACK;
              drive_next    = 1'b1;
            end else if (!push_reg) begin
              beat_next  = '{index: idx_reg, data: sh_reg};
              push_next  = 1'b1;
              st_next    = SIT_WACK;
              drive_next = 1'b1;
              if (!i_trap_enable) begin
                idx_next = idx_reg + 8'h01;
              end  // Trap keeps idx fixed
            end else begin
              st_next = SIT_IDLE;  // Write path full: byte refused with no acknowledge
            end
          end
        end
        SIT_AACK, SIT_WACK: begin
          if (scl_fall) begin
            drive_next = 1'b0;
            if (st_reg == SIT_AACK && rd_reg) begin
              st_next    = SIT_RTX;
              sh_next    = i_read_data;
              drive_next = !i_read_data[7];
              idx_next   = idx_reg + 8'h01;
              bit_next   = 4'h1;
            end else begin
              st_next = SIT_WRX;
            end
          end
        end
        SIT_RTX: begin
          if (scl_fall) begin
            if (bit_reg == SIT_ACK_BIT) begin
              st_next    = SIT_RACK;
              drive_next = 1'b0;
            end else begin
              drive_next = !sh_reg[SIT_LAST_BIT[2:0] - bit_reg[2:0]];
              bit_next   = bit_reg + 4'h1;
            end
          end
        end
        SIT_RACK: begin
          if (scl_rise) begin
            rd_next = !sda;
          end
          if (scl_fall) begin
            if (rd_reg) begin
              st_next    = SIT_RTX;
              sh_next    = i_read_data;
              drive_next = !i_read_data[7];
              idx_next   = idx_reg + 8'h01;
              bit_next   = 4'h1;
            end else begin
              st_next = SIT_IDLE;
            end
          end
        end
        default: begin
          st_next    = SIT_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_reg       <= SIT_IDLE;
      bit_reg      <= '0;
      sh_reg       <= '0;
      idx_reg      <= SIT_INDEX_RESET;
      base_reg     <= SIT_INDEX_RESET;
      have_idx_reg <= 1'b0;
      rd_reg       <= 1'b0;
      drive_reg    <= 1'b0;
      toggled_reg  <= 1'b0;
      busy_reg     <= 1'b0;
      push_reg     <= 1'b0;
      beat_reg     <= '0;
      wdt_reg      <= '0;
    end else begin
      st_reg       <= st_next;
      bit_reg      <= bit_next;
      sh_reg       <= sh_next;
      idx_reg      <= idx_next;
      base_reg     <= base_next;
      have_idx_reg <= have_idx_next;
      rd_reg       <= rd_next;
      drive_reg    <= drive_next;
      toggled_reg  <= toggled_next;
      busy_reg     <= busy_next;
      push_reg     <= push_next;
      beat_reg     <= beat_next;
      wdt_reg      <= wdt_next;
    end
  end

  // Open-drain: only ever drive low
  assign o_bus_data_pin_out = 1'b0;
  assign o_bus_data_pin_oe  = drive_reg;
  assign o_read_index       = idx_reg;
  assign o_busy             = busy_reg;
  assign o_wdt_fired        = wdt_fire;

  sit_fifo #(
    .WIDTH ($bits(sit_wbeat_t)),
    .DEPTH (SIT_FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (push_reg),
    .o_in_ready  (fifo_ready),
    .i_in_data   (beat_reg),
    .o_out_valid (o_write_valid),
    .i_out_ready (i_write_ready),
    .o_out_data  (o_write_beat)
  );
endmodule

// File: sit_chk.sv
// Port checker for the two-wire target
`timescale 1ns/1ps
module sit_chk (
  input wire logic                i_clock,
  input wire logic                i_rst,
  input wire logic                i_bus_clock_pin,
  input wire logic                i_bus_data_pin_in,
  input wire logic                o_bus_data_pin_out,
  input wire logic                o_bus_data_pin_oe,
  input wire logic                i_write_ready,
  input wire logic                o_write_valid,
  input wire sit_pkg::sit_wbeat_t o_write_beat,
  input wire logic                o_busy,
  input wire logic                o_wdt_fired
);
  import sit_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_start; i_bus_clock_pin && $fell(i_bus_data_pin_in); endsequence
  sequence s_stop; i_bus_clock_pin && $rose(i_bus_data_pin_in) && o_busy; endsequence
  // Three high cycles: the sync delay is over, so the data line must be frozen
  sequence s_clk_hi; i_bus_clock_pin [*3]; endsequence
  property p_od; o_bus_data_pin_out == 1'b0; endproperty
  property p_rst; $past(i_rst) |-> !o_busy && !o_bus_data_pin_oe && !o_write_valid; endproperty
  property p_start; s_start |-> ##[1:8] o_busy; endproperty
  property p_stop; s_stop |-> ##[1:8] !o_busy; endproperty
  property p_ack_hold; s_clk_hi |-> $stable(o_bus_data_pin_oe); endproperty
  property p_hold; o_write_valid && !i_write_ready |=> o_write_valid && $stable(o_write_beat); endproperty
  property p_wdt; o_wdt_fired |-> ##[0:1] !o_bus_data_pin_oe; endproperty
  property p_idle; !o_busy && !$past(o_busy) |-> !o_bus_data_pin_oe; endproperty
  a_od: assert property (p_od) else $error("data line driven high");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  a_start: assert property (p_start) else $error("start not seen");
  a_stop: assert property (p_stop) else $error("stop not seen");
  a_ack_hold: assert property (p_ack_hold) else $error("data moved in clock high");
  a_hold: assert property (p_hold) else $error("write beat dropped");
  a_wdt: assert property (p_wdt) else $error("bus kept after watchdog");
  a_idle: assert property (p_idle) else $error("data pulled while idle");
endmodule

bind sit_target sit_chk u_chk (
  .i_clock(i_clock),
  .i_rst(i_rst),
  .i_bus_clock_pin(i_bus_clock_pin),
  .i_bus_data_pin_in(i_bus_data_pin_in),
  .o_bus_data_pin_out(o_bus_data_pin_out),
  .o_bus_data_pin_oe(o_bus_data_pin_oe),
  .i_write_ready(i_write_ready),
  .o_write_valid(o_write_valid),
  .o_write_beat(o_write_beat),
  .o_busy(o_busy),
  .o_wdt_fired(o_wdt_fired)
);

// File: sit_host.sv
// Bus controller model driving clock and open-drain data
`timescale 1ns/1ps
module sit_host (
  input  wire logic i_clock,
  input  wire logic i_bus_data_pin_in,
  output logic      o_bus_clock_pin,
  output logic      o_bus_data_pin_oe
);
  initial begin
    o_bus_clock_pin = 1'b1;
    o_bus_data_pin_oe = 1'b0;
  end
  task automatic hcyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Long low wait lets an acknowledge end before the clock rises
  task automatic start();
    o_bus_data_pin_oe = 1'b0;
    hcyc(6);
    o_bus_clock_pin = 1'b1;
    hcyc(3);
    o_bus_data_pin_oe = 1'b1;
    hcyc(3);
    o_bus_clock_pin = 1'b0;
  endtask
  // Stop, then the post-write idle gap of 2 us
  task automatic stop();
    o_bus_data_pin_oe = 1'b1;
    hcyc(6);
    o_bus_clock_pin = 1'b1;
    hcyc(3);
    o_bus_data_pin_oe = 1'b0;
    hcyc(20);
  endtask
  // 0.8 us bit, above the top rate, so the oversampler is run beyond its rating
  task automatic bit_io(input logic b, output logic r);
    hcyc(2);
    o_bus_data_pin_oe = !b;
    hcyc(2);
    o_bus_clock_pin = 1'b1;
    hcyc(4);
    r = i_bus_data_pin_in;
    o_bus_clock_pin = 1'b0;
  endtask
  // MSB first, ninth clock for acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                      output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack, nak);
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the two-wire target port
`timescale 1ns/1ps
module testbench;
  import sit_pkg::*;
  logic       i_clock, i_rst, sel, trap, rdy, scl, h_oe, d_out, d_oe, wv, busy, wdt;
  logic [7:0] ridx, rx;
  logic       nak;
  sit_wbeat_t beat;
  int         miscompares = 0;
  int         checks = 0;
  int         cyc = 0;
  // Pull-up: the line reads high unless someone pulls it
  wire        sda = !(h_oe || (d_oe && !d_out));
  sit_target #(.WDT_CYCLES(64)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_address_select_pin(sel),
    .i_bus_clock_pin(scl), .i_bus_data_pin_in(sda), .o_bus_data_pin_out(d_out),
    .o_bus_data_pin_oe(d_oe), .i_trap_enable(trap), .i_read_data(ridx ^ 8'hA5),
    .o_read_index(ridx), .o_write_valid(wv), .i_write_ready(rdy),
    .o_write_beat(beat), .o_busy(busy), .o_wdt_fired(wdt));
  sit_host u_host (.i_clock(i_clock), .i_bus_data_pin_in(sda), .o_bus_clock_pin(scl),
    .o_bus_data_pin_oe(h_oe));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  // Address, index, then cnt data bytes from d0; n counts acknowledged bytes
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d0,
                    input int cnt, output logic an, output int n);
    n = 0;
    u_host.start();
    u_host.xfer({a, 1'b0}, 1'b1, rx, an);
    u_host.xfer(idx, 1'b1, rx, nak);
    for (int k = 0; k < cnt; k++) begin
      u_host.xfer(d0 + k[7:0], 1'b1, rx, nak);
      n += (nak === 1'b0);
    end
    u_host.stop();
  endtask
  // Drains with a three-cycle stall before each take
  task automatic drain(input int n, input logic [7:0] i0, input logic [7:0] d0,
                       input logic inc);
    int w;
    for (int k = 0; k < n; k++) begin
      w = 0;
      while (wv !== 1'b1 && w < 100) begin
        @(posedge i_clock);
        #1;
        w++;
      end
      chk("beat", {i0 + (inc ? k[7:0] : 8'h00), d0 + k[7:0]}, beat);
      repeat (3) @(posedge i_clock);
      #1;
      rdy = 1'b1;
      @(posedge i_clock);
      #1;
      rdy = 1'b0;
    end
    repeat (3) @(posedge i_clock);
    #1;
    chk("fifo empty", 16'h0, wv);
  endtask
  task automatic t_read(input logic [6:0] a, input logic [7:0] idx, input logic setidx);
    logic an;
    u_host.start();
    chk("busy", 16'h1, busy);
    if (setidx) begin
      u_host.xfer({a, 1'b0}, 1'b1, rx, an);
      u_host.xfer(idx, 1'b1, rx, nak);
      u_host.start();
    end
    u_host.xfer({a, 1'b1}, 1'b1, rx, an);
    chk("read addr ack", 16'h0, an);
    u_host.xfer(8'hFF, 1'b0, rx, nak);
    chk("read byte 0", idx ^ 8'hA5, rx);
    u_host.xfer(8'hFF, 1'b1, rx, nak);
    chk("read byte 1", (idx + 8'h01) ^ 8'hA5, rx);
    u_host.stop();
    chk("idle after stop", 16'h0, busy);
    chk("no beat from read", 16'h0, wv);
    $display("test read done");
  endtask
  task automatic t_fill();
    logic an;
    int   n;
    wr(SIT_ADDR_LOW, 8'h41, 8'h01, 10, an, n);
    chk("write addr ack", 16'h0, an);
    chk("fifo refused", 16'h1, nak);
    chk("fifo took depth", 16'h1, n >= SIT_FIFO_DEPTH);
    drain(n, 8'h41, 8'h01, 1'b1);
    $display("test fill done");
  endtask
  task automatic t_trap();
    logic an;
    int   n;
    sel = 1'b1;
    trap = 1'b1;
    wr(SIT_ADDR_LOW, 8'h45, 8'h80, 1, an, n);
    chk("foreign addr nack", 16'h1, an);
    chk("foreign data", 16'h0, wv);
    wr(SIT_ADDR_HIGH, 8'h45, 8'h80, 3, an, n);
    chk("alt addr ack", 16'h0, an);
    drain(3, 8'h45, 8'h80, 1'b0);
    trap = 1'b0;
    $display("test trap done");
  endtask
  task automatic t_wdt();
    int w;
    w = 0;
    u_host.start();
    // Clock parked low in the acknowledge slot, so the port keeps the data line low
    for (int i = 7; i >= 0; i--)
      u_host.bit_io(i == 0 ? 1'b0 : SIT_ADDR_HIGH[i-1], nak);
    while (wdt !== 1'b1 && w < 200) begin
      @(posedge i_clock);
      #1;
      w++;
    end
    chk("wdt time", 16'h1, w >= 60 && w <= 80);
    @(posedge i_clock);
    #1;
    chk("wdt release", 16'h0, d_oe);
    u_host.stop();
    $display("test wdt done");
  endtask
  initial begin
    i_rst = 1'b1;
    sel = 1'b0;
    trap = 1'b0;
    rdy = 1'b0;
    repeat (6) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    repeat (4) @(posedge i_clock);
    #1;
    t_read(SIT_ADDR_LOW, SIT_INDEX_RESET, 1'b0);
    t_fill();
    t_trap();
    t_read(SIT_ADDR_HIGH, 8'h12, 1'b1);
    t_read(SIT_ADDR_HIGH, 8'h12, 1'b0);
    t_wdt();
    finish_test();
  end
endmodule
